// [usart_spc_pkg.sv]
// Purpose: shared constants for the special-character map and its bus
// Assumes: 8-bit processor bus with 6-bit register offsets
// Notes:   apb offsets and fields belong to the controller end
package usart_spc_pkg;
  // processor bus shape and map size
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 8;
  localparam int CODE_W    = 7;
  localparam int MAP_DEPTH = 128;
  // device register offsets
  localparam logic [5:0] OFF_RX_DATA     = 6'h20;
  localparam logic [5:0] OFF_LINE_STATUS = 6'h25;
  localparam logic [5:0] OFF_STATUS      = 6'h28;
  localparam logic [5:0] OFF_INDEX       = 6'h29;
  localparam logic [5:0] OFF_COMMAND     = 6'h2A;
  // device field positions
  localparam int STATUS_RX_ON_BIT    = 7;
  localparam int STATUS_SPC_AVAIL    = 2;
  localparam int LINE_SPC_IN_BUF     = 7;
  localparam int LINE_OVERRUN        = 1;
  localparam int LINE_DATA_AVAIL     = 0;
  localparam int COMMAND_ENTRY_BIT   = 0;
  localparam int INDEX_UNUSED_BIT    = 7;
  // device reset and fixed values
  localparam logic [6:0] INDEX_RESET       = 7'h00;
  localparam logic [7:0] RX_DATA_RESET     = 8'h00;
  localparam logic [7:0] CMD_BLOCKED_READ  = 8'hFF;
  localparam logic [7:0] COMMAND_USED_MASK = 8'h01;
  // controller apb map
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] APB_OFF_ORDER  = 12'h000;
  localparam logic [11:0] APB_OFF_REPORT = 12'h004;
  localparam int ORDER_ADDR_LSB  = 0;
  localparam int ORDER_WRITE_BIT = 8;
  localparam int ORDER_DATA_LSB  = 16;
  localparam int REPORT_BUSY_BIT = 0;
  localparam int REPORT_REFUSED  = 1;
  localparam int REPORT_DATA_LSB = 8;
  // controller sequencer
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_REQ  = 2'b01,
    HOST_WAIT = 2'b10
  } host_state_t;
endpackage

// [processor_bus_port_if.sv]
// Purpose: 8-bit register bus between local controller and serial port
// Assumes: both ends on pclk; one request pulse, one ack pulse
// Notes:   ack and read data come one cycle after the request
`timescale 1ns/1ps
interface processor_bus_port_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic                             req;
  logic                             write;
  logic [usart_spc_pkg::ADDR_W-1:0] addr;
  logic [usart_spc_pkg::DATA_W-1:0] wdata;
  logic [usart_spc_pkg::DATA_W-1:0] rdata;
  logic                             ack;
  modport device (
    input  pclk,
    input  presetn,
    input  req,
    input  write,
    input  addr,
    input  wdata,
    output rdata,
    output ack
  );
  modport host (
    input  pclk,
    input  presetn,
    input  rdata,
    input  ack,
    output req,
    output write,
    output addr,
    output wdata
  );
endinterface

// [special_char_map.sv]
// Purpose: 128-entry one-bit map of special character codes
// Assumes: one write port, two combinational read ports
// Notes:   bus and receiver read different indices at once
`timescale 1ns/1ps
module special_char_map (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             write_en,
  input  wire logic                             write_value,
  input  wire logic [usart_spc_pkg::CODE_W-1:0] write_index,
  input  wire logic [usart_spc_pkg::CODE_W-1:0] bus_index,
  input  wire logic [usart_spc_pkg::CODE_W-1:0] rx_index,
  output logic                                  bus_entry,
  output logic                                  rx_entry
);
  import usart_spc_pkg::*;
  logic [MAP_DEPTH-1:0] entries;
  logic [MAP_DEPTH-1:0] next_entries;

  // one flag per entry, only the addressed one takes the write
  genvar g;
  generate
    for (g = 0; g < MAP_DEPTH; g++) begin : g_entry
      always_comb begin
        next_entries[g] = entries[g];
        if (write_en && (write_index == CODE_W'(g))) begin
          next_entries[g] = write_value;
        end
      end
    end
  endgenerate

  // whole map clears on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entries <= '0;
    end else begin
      entries <= next_entries;
    end
  end

  // read ports
  assign bus_entry = entries[bus_index];
  assign rx_entry  = entries[rx_index];
endmodule

// [special_char_device.sv]
// Purpose: serial-port receive side with special-character recognition
// Assumes: received characters arrive on pclk from same-domain logic
// Notes:   one-entry receive holding register stands in for the buffer
`timescale 1ns/1ps
module special_char_device (
  processor_bus_port_if.device                  bus,
  input  wire logic                             rx_char_valid,
  input  wire logic [usart_spc_pkg::DATA_W-1:0] rx_char,
  output logic                                  rx_enable,
  output logic                                  spc_available
);
  import usart_spc_pkg::*;

  // register state
  logic              receiver_on_flag;
  logic              next_receiver_on_flag;
  logic [CODE_W-1:0] special_code_index;
  logic [CODE_W-1:0] next_special_code_index;
  logic              rx_full;
  logic              next_rx_full;
  logic [DATA_W-1:0] rx_data;
  logic [DATA_W-1:0] next_rx_data;
  logic              rx_tag;
  logic              next_rx_tag;
  logic              line_spc;
  logic              next_line_spc;
  logic              line_ovr;
  logic              next_line_ovr;
  logic              ack;
  logic              next_ack;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;

  // decode and map wiring
  logic              bus_rd;
  logic              bus_wr;
  logic              hit_data;
  logic              hit_line;
  logic              hit_status;
  logic              hit_index;
  logic              hit_command;
  logic              map_write_en;
  logic              bus_entry;
  logic              rx_entry;
  logic              rx_take;
  logic              rx_pop;
  logic              line_read;
  logic [DATA_W-1:0] read_value;

  // register decode for the 8-bit processor bus
  assign bus_rd      = bus.req && !bus.write;
  assign bus_wr      = bus.req && bus.write;
  assign hit_data    = (bus.addr == OFF_RX_DATA);
  assign hit_line    = (bus.addr == OFF_LINE_STATUS);
  assign hit_status  = (bus.addr == OFF_STATUS);
  assign hit_index   = (bus.addr == OFF_INDEX);
  assign hit_command = (bus.addr == OFF_COMMAND);

  // map writes are dropped while receiving so the receiver lookup
  // never races a bus update; software must stop the receiver first
  assign map_write_en = bus_wr && hit_command && !receiver_on_flag;

  // receiver takes characters only while enabled
  assign rx_take   = rx_char_valid && receiver_on_flag;
  assign rx_pop    = bus_rd && hit_data && rx_full;
  assign line_read = bus_rd && hit_line;

  special_char_map u_map (
    .pclk        (bus.pclk),
    .presetn     (bus.presetn),
    .write_en    (map_write_en),
    .write_value (bus.wdata[COMMAND_ENTRY_BIT]),
    .write_index (special_code_index),
    .bus_index   (special_code_index),
    .rx_index    (rx_char[CODE_W-1:0]),
    .bus_entry   (bus_entry),
    .rx_entry    (rx_entry)
  );

  // read data mux, reserved bits and unmapped offsets read zero, except the all-ones command read while receiving
  always_comb begin
    read_value = '0;
    case (bus.addr)
      OFF_RX_DATA: begin
        read_value = rx_data;
      end
      OFF_LINE_STATUS: begin
        read_value[LINE_SPC_IN_BUF] = line_spc;
        read_value[LINE_OVERRUN]    = line_ovr;
        read_value[LINE_DATA_AVAIL] = rx_full;
      end
      OFF_STATUS: begin
        read_value[STATUS_RX_ON_BIT] = receiver_on_flag;
        read_value[STATUS_SPC_AVAIL] = rx_full && rx_tag;
      end
      OFF_INDEX: begin
        read_value[CODE_W-1:0] = special_code_index; // bit 7 reads zero
      end
      OFF_COMMAND: begin
        if (receiver_on_flag) begin
          read_value = CMD_BLOCKED_READ;
        end else begin
          read_value[COMMAND_ENTRY_BIT] = bus_entry;
        end
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  // control registers written from the bus
  always_comb begin
    next_receiver_on_flag   = receiver_on_flag;
    next_special_code_index = special_code_index;
    if (bus_wr && hit_status) begin
      next_receiver_on_flag = bus.wdata[STATUS_RX_ON_BIT];
    end
    if (bus_wr && hit_index) begin
      next_special_code_index = bus.wdata[CODE_W-1:0];
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      receiver_on_flag   <= 1'b0;
      special_code_index <= INDEX_RESET;
    end else begin
      receiver_on_flag   <= next_receiver_on_flag;
      special_code_index <= next_special_code_index;
    end
  end

  // holding register; a new character beats a pop in the same cycle
  always_comb begin
    next_rx_full = rx_full;
    next_rx_data = rx_data;
    next_rx_tag  = rx_tag;
    if (rx_pop) begin
      next_rx_full = 1'b0;
      next_rx_tag  = 1'b0;
    end
    if (rx_take) begin
      next_rx_full = 1'b1;
      next_rx_data = rx_char;
      next_rx_tag  = rx_entry;
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      rx_full <= 1'b0;
      rx_data <= RX_DATA_RESET;
      rx_tag  <= 1'b0;
    end else begin
      rx_full <= next_rx_full;
      rx_data <= next_rx_data;
      rx_tag  <= next_rx_tag;
    end
  end

  // sticky line flags, clear on line-status read, set wins the tie
  always_comb begin
    next_line_spc = line_spc;
    next_line_ovr = line_ovr;
    if (line_read) begin
      next_line_spc = 1'b0;
      next_line_ovr = 1'b0;
    end
    if (rx_take && rx_entry) begin
      next_line_spc = 1'b1;
    end
    if (rx_take && rx_full && !rx_pop) begin
      next_line_ovr = 1'b1; // old character lost
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      line_spc <= 1'b0;
      line_ovr <= 1'b0;
    end else begin
      line_spc <= next_line_spc;
      line_ovr <= next_line_ovr;
    end
  end

  // answer one cycle after every request; read data holds until next read
  always_comb begin
    next_ack   = bus.req;
    next_rdata = rdata;
    if (bus_rd) begin
      next_rdata = read_value;
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // outputs from flip-flops, except spc_available, the AND of rx_full and rx_tag
  assign bus.ack       = ack;
  assign bus.rdata     = rdata;
  assign rx_enable     = receiver_on_flag;
  assign spc_available = rx_full && rx_tag;
endmodule

// [special_char_host.sv]
// Purpose: local controller driving the 8-bit bus on orders over apb
// Assumes: zero-wait apb slave, one order in flight at a time
// Notes:   command accesses are refused while the receiver runs
`timescale 1ns/1ps
module special_char_host (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [usart_spc_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  processor_bus_port_if.host                        bus
);
  import usart_spc_pkg::*;
  host_state_t       state;
  host_state_t       next_state;
  logic              order_write;
  logic              next_order_write;
  logic [ADDR_W-1:0] order_addr;
  logic [ADDR_W-1:0] next_order_addr;
  logic [DATA_W-1:0] order_data;
  logic [DATA_W-1:0] next_order_data;
  logic [DATA_W-1:0] read_data;
  logic [DATA_W-1:0] next_read_data;
  logic              refused;
  logic              next_refused;
  logic              rx_on_shadow;
  logic              next_rx_on_shadow;
  logic              order_go;
  logic [ADDR_W-1:0] new_addr;
  logic [DATA_W-1:0] new_data;

  // an order is taken only when idle; writes while busy are dropped
  assign order_go = psel && penable && pwrite && (paddr == APB_OFF_ORDER) && (state == HOST_IDLE);
  assign new_addr = pwdata[ORDER_ADDR_LSB +: ADDR_W];

  // clean up data the device treats as unused
  always_comb begin
    new_data = pwdata[ORDER_DATA_LSB +: DATA_W];
    if (new_addr == OFF_INDEX) begin
      new_data[INDEX_UNUSED_BIT] = 1'b0;
    end
    if (new_addr == OFF_COMMAND) begin
      new_data = new_data & COMMAND_USED_MASK;
    end
  end

  // sequencer: request pulse, then wait for the device's ack
  always_comb begin
    next_state        = state;
    next_order_write  = order_write;
    next_order_addr   = order_addr;
    next_order_data   = order_data;
    next_read_data    = read_data;
    next_refused      = refused;
    next_rx_on_shadow = rx_on_shadow;
    case (state)
      HOST_IDLE: begin
        if (order_go) begin
          // the shadow only knows what this controller wrote last
          if (rx_on_shadow && (new_addr == OFF_COMMAND)) begin
            next_refused = 1'b1;
          end else begin
            next_refused     = 1'b0;
            next_order_write = pwdata[ORDER_WRITE_BIT];
            next_order_addr  = new_addr;
            next_order_data  = new_data;
            next_state       = HOST_REQ;
          end
        end
      end
      HOST_REQ: begin
        next_state = HOST_WAIT;
      end
      HOST_WAIT: begin
        if (bus.ack) begin
          next_state = HOST_IDLE;
          if (!order_write) begin
            next_read_data = bus.rdata;
          end else if (order_addr == OFF_STATUS) begin
            next_rx_on_shadow = order_data[STATUS_RX_ON_BIT];
          end
        end
      end
      default: begin
        next_state = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= HOST_IDLE;
      order_write  <= 1'b0;
      order_addr   <= '0;
      order_data   <= '0;
      read_data    <= '0;
      refused      <= 1'b0;
      rx_on_shadow <= 1'b0;
    end else begin
      state        <= next_state;
      order_write  <= next_order_write;
      order_addr   <= next_order_addr;
      order_data   <= next_order_data;
      read_data    <= next_read_data;
      refused      <= next_refused;
      rx_on_shadow <= next_rx_on_shadow;
    end
  end

  // bus side
  assign bus.req   = (state == HOST_REQ);
  assign bus.write = order_write;
  assign bus.addr  = order_addr;
  assign bus.wdata = order_data;

  // apb read mux, unmapped reads give zero
  always_comb begin
    prdata = '0;
    if (paddr == APB_OFF_REPORT) begin
      prdata[REPORT_BUSY_BIT]              = (state != HOST_IDLE);
      prdata[REPORT_REFUSED]               = refused;
      prdata[REPORT_DATA_LSB +: DATA_W]    = read_data;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
endmodule

// [special_char_monitor.sv]
// Purpose: assertions on the processor bus between the two ends
// Assumes: host issues at most one request every other cycle
// Notes:   keeps its own copy of index, receiver state and map
`timescale 1ns/1ps
module special_char_monitor (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             req,
  input wire logic                             write,
  input wire logic [usart_spc_pkg::ADDR_W-1:0] addr,
  input wire logic [usart_spc_pkg::DATA_W-1:0] wdata,
  input wire logic [usart_spc_pkg::DATA_W-1:0] rdata,
  input wire logic                             ack
);
  import usart_spc_pkg::*;
  logic [MAP_DEPTH-1:0] map;
  logic [MAP_DEPTH-1:0] next_map;
  logic [CODE_W-1:0]    idx;
  logic [CODE_W-1:0]    next_idx;
  logic                 on;
  logic                 next_on;
  logic                 wr_req;
  logic                 rd_req;
  assign wr_req = req && write;
  assign rd_req = req && !write;
  // shadow of what the device should hold, updated at each write request
  always_comb begin
    next_map = map;
    next_idx = idx;
    next_on  = on;
    if (wr_req && addr == OFF_INDEX) next_idx = wdata[CODE_W-1:0];
    if (wr_req && addr == OFF_STATUS) next_on = wdata[STATUS_RX_ON_BIT];
    if (wr_req && addr == OFF_COMMAND && !on) next_map[idx] = wdata[0];
  end
  // cleared like the device, so a stale map cannot mask a reset fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map <= '0;
      idx <= '0;
      on  <= 1'b0;
    end else begin
      map <= next_map;
      idx <= next_idx;
      on  <= next_on;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_after_req_a: assert property (req |=> ack)
    else $error("no ack one cycle after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  entry_read_a: assert property (rd_req && addr == OFF_COMMAND && !on |=> rdata == {7'h00, map[idx]})
    else $error("command read does not show map entry");
  blocked_read_a: assert property (rd_req && addr == OFF_COMMAND && on |=> rdata == CMD_BLOCKED_READ)
    else $error("command read while receiving not all ones");
  index_read_a: assert property (rd_req && addr == OFF_INDEX |=> rdata == {1'b0, idx})
    else $error("index read mismatch");
  rdata_hold_a: assert property (!rd_req |=> $stable(rdata))
    else $error("read data changed without a read");
  index_top_zero_a: assert property (wr_req && addr == OFF_INDEX |-> !wdata[INDEX_UNUSED_BIT])
    else $error("index written with top bit set");
  cmd_upper_zero_a: assert property (wr_req && addr == OFF_COMMAND |-> wdata[7:1] == 7'h00)
    else $error("command upper bits written nonzero");
  map_when_off_a: assert property (req && addr == OFF_COMMAND |-> !on)
    else $error("map accessed while receiver on");
endmodule

// [tb_usart_special_char_bitmap.sv]
// Purpose: drives the controller over apb against the device end
// Assumes: apb slave answers at once; orders polled until not busy
// Notes:   blocked command reads never reach the bus from this host
`timescale 1ns/1ps
module tb_usart_special_char_bitmap;
  import usart_spc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        rx_char_valid;
  logic [7:0]  rx_char;
  logic        rx_enable;
  logic        spc_available;
  logic [31:0] rep;
  logic [7:0]  codes [3];
  int          fails;
  int          checks;
  processor_bus_port_if bus_if (.pclk(pclk), .presetn(presetn));
  special_char_host i_special_char_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .bus(bus_if.host));
  special_char_device i_special_char_device (.bus(bus_if.device), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_enable(rx_enable), .spc_available(spc_available));
  special_char_monitor i_special_char_monitor (.pclk(pclk), .presetn(presetn), .req(bus_if.req),
    .write(bus_if.write), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .ack(bus_if.ack));
  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic test_done;
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one bus order, then poll the report until the host is idle again
  task automatic order(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, APB_OFF_ORDER, {8'h00, d, 7'h00, w, 2'b00, a}, rep);
    n = 0;
    do begin
      apb(1'b0, APB_OFF_REPORT, 32'h0000_0000, rep);
      n++;
    end while (rep[REPORT_BUSY_BIT] !== 1'b0 && n < 20);
    if (rep[REPORT_BUSY_BIT] !== 1'b0) begin
      fails++;
      test_done();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string name);
    order(1'b0, a, 8'h00);
    chk(name, exp, rep[15:8]);
  endtask
  // one received character, offered for a single cycle
  task automatic rx(input logic [7:0] c);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
  initial begin
    fails = 0;
    checks = 0;
    codes = '{8'h00, 8'h41, 8'h7F};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_INDEX, 8'h00, "index reset");
    // set each code, check its neighbour stays clear, then clear all but 0x41
    foreach (codes[i]) begin
      order(1'b1, OFF_INDEX, codes[i]);
      rd(OFF_COMMAND, 8'h00, "entry after reset");
      order(1'b1, OFF_COMMAND, 8'h01);
      rd(OFF_COMMAND, 8'h01, "entry set");
      order(1'b1, OFF_INDEX, codes[i] ^ 8'h01);
      rd(OFF_COMMAND, 8'h00, "neighbour entry");
      order(1'b1, OFF_INDEX, codes[i]);
      if (codes[i] != 8'h41) begin
        order(1'b1, OFF_COMMAND, 8'h00);
        rd(OFF_COMMAND, 8'h00, "entry cleared");
      end
    end
    order(1'b1, OFF_INDEX, 8'hC1);
    rd(OFF_INDEX, 8'h41, "index top bit");
    order(1'b1, OFF_COMMAND, 8'hFE);
    rd(OFF_COMMAND, 8'h00, "command upper bits");
    order(1'b1, OFF_COMMAND, 8'h01);
    rd(OFF_COMMAND, 8'h01, "entry via index");
    order(1'b1, OFF_STATUS, 8'h80);
    chk("rx_enable on", 8'h01, {7'h00, rx_enable});
    order(1'b0, OFF_COMMAND, 8'h00);
    chk("refused", 8'h01, {7'h00, rep[REPORT_REFUSED]});
    rx(8'hC1);
    chk("spc_available set", 8'h01, {7'h00, spc_available});
    rd(OFF_LINE_STATUS, 8'h81, "line special");
    rd(OFF_LINE_STATUS, 8'h01, "line after read");
    rd(OFF_STATUS, 8'h84, "status special");
    rd(OFF_RX_DATA, 8'hC1, "rx data");
    chk("spc_available clear", 8'h00, {7'h00, spc_available});
    rx(8'h42);
    chk("normal char", 8'h00, {7'h00, spc_available});
    rd(OFF_LINE_STATUS, 8'h01, "line normal");
    rd(OFF_RX_DATA, 8'h42, "rx data normal");
    // second character lands on a full holding register: overrun, newest kept
    rx(8'h42);
    rx(8'hC1);
    rd(OFF_LINE_STATUS, 8'h83, "line overrun special");
    rd(OFF_RX_DATA, 8'hC1, "rx data overwrite");
    order(1'b1, OFF_STATUS, 8'h00);
    chk("rx_enable off", 8'h00, {7'h00, rx_enable});
    rd(OFF_COMMAND, 8'h01, "entry after off");
    chk("refused cleared", 8'h00, {7'h00, rep[REPORT_REFUSED]});
    rx(8'hC1);
    rd(OFF_LINE_STATUS, 8'h00, "dropped char");
    // mid-run reset must wipe the entry that is still set at 0x41
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_INDEX, 8'h00, "index after mid reset");
    order(1'b1, OFF_INDEX, 8'h41);
    rd(OFF_COMMAND, 8'h00, "entry after mid reset");
    test_done();
  end
endmodule
